// ---- core/bpmr_pkg.sv ----
// bpmr_pkg: offsets, field positions, reset values and carrier types of the bridge
// power management, serial eeprom command and secondary device mask registers.
// assumes one bridge clock; configuration accesses arrive as single-cycle strobes.
`default_nettype none
package bpmr_pkg;
  // configuration space byte offsets
  localparam logic [11:0] BPMR_OFF_PMCS = 12'h0A4;
  localparam logic [11:0] BPMR_OFF_EECMD = 12'h0AC;
  localparam logic [11:0] BPMR_OFF_DEVMSK = 12'h0B0;
  // power management control word fields
  localparam int BPMR_PM_WAKE_EN_BIT = 8;
  localparam int BPMR_PM_NO_SOFT_RST_BIT = 3;
  localparam logic [1:0] BPMR_PS_D0 = 2'h0;
  localparam logic [1:0] BPMR_PS_D3HOT = 2'h3;
  localparam logic BPMR_D1_SUPPORTED = 1'h0;
  localparam logic BPMR_D2_SUPPORTED = 1'h0;
  localparam logic BPMR_WAKE_EN_RESET = 1'h0;
  // eeprom command fields
  localparam int BPMR_EE_CMD_LSB = 28;
  localparam int BPMR_EE_WIDTH_LSB = 26;
  localparam int BPMR_EE_BUSY_BIT = 25;
  localparam int BPMR_EE_VALID_BIT = 24;
  localparam int BPMR_EE_ADDR_LSB = 8;
  localparam logic [1:0] BPMR_EE_CMD_READ = 2'h1;
  localparam logic [1:0] BPMR_EE_CMD_WRITE = 2'h2;
  localparam logic [1:0] BPMR_EE_NO_DEVICE = 2'h0;
  // device mask: implemented bits 29,25,23,22,21,20,17
  localparam logic [31:0] BPMR_DEVMSK_IMPL = 32'h22F20000;
  localparam logic [31:0] BPMR_DEVMSK_RESET = 32'h00000000;
  localparam logic [4:0] BPMR_REROUTE_DEV = 5'h0F;
  localparam logic [4:0] BPMR_REROUTE_LINE = 5'h1F;
  localparam int BPMR_IDSEL_BASE = 16;

  typedef enum logic [1:0] {
    BPMR_EE_IDLE = 2'b00,
    BPMR_EE_WAIT = 2'b01
  } bpmr_ee_state_t;

  // request to the serial eeprom engine
  typedef struct packed {
    logic start;
    logic [1:0] cmd;
    logic [1:0] width;
    logic [15:0] addr;
    logic [7:0] data;
  } bpmr_ee_req_t;

  // answer from the serial eeprom engine
  typedef struct packed {
    logic done;
    logic [7:0] data;
  } bpmr_ee_rsp_t;

  typedef struct packed {
    logic [1:0] power_state_field;
    logic wake_event_enable;
    logic wake_retained;
    logic [1:0] ee_cmd;
    logic [1:0] ee_width;
    logic busy;
    logic [15:0] ee_addr;
    logic [7:0] ee_data;
    bpmr_ee_state_t ee_state;
    bpmr_ee_req_t ee_req;
    logic [31:0] secondary_device_select_mask;
    logic [31:0] rdata;
    logic rvalid;
    logic [31:0] idsel;
    logic wake_event;
  } bpmr_state_t;
endpackage : bpmr_pkg
`default_nettype wire

// ---- core/bpmr_regs.sv ----
// bpmr_regs: power management control low half, serial eeprom command register and
// secondary bus device mask with type 0 select line rerouting.
// assumes configuration reads/writes as one-cycle strobes, full 32-bit words.
// limitation: the serial eeprom engine sits outside; only its request and answer ports live here.
`default_nettype none
module bpmr_regs (
  input wire logic clk,
  input wire logic resetn,
  input wire logic cold_wake,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [11:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  input wire logic pme_request,
  output logic wake_event,
  output bpmr_pkg::bpmr_ee_req_t ee_req,
  input wire bpmr_pkg::bpmr_ee_rsp_t ee_rsp,
  input wire logic [4:0] t0_device,
  output logic [31:0] t0_idsel
);
  logic rst_meta;
  logic rst_sync;
  bpmr_pkg::bpmr_state_t st;
  bpmr_pkg::bpmr_state_t next_st;

  // reset release through two flops so all state leaves reset on one edge
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // the one power state code that may be taken; D1/D2 fall back to current
  function automatic logic [1:0] bpmr_ps_next(input logic [1:0] cur, input logic [1:0] req);
    logic ok;
    ok = 1'b1;
    if (req == 2'h1)
      ok = bpmr_pkg::BPMR_D1_SUPPORTED;
    if (req == 2'h2)
      ok = bpmr_pkg::BPMR_D2_SUPPORTED;
    return ok ? req : cur;
  endfunction

  // read image of the power management low half
  function automatic logic [31:0] bpmr_pmcs_image(input logic [1:0] ps, input logic en);
    logic [31:0] w;
    w = 32'h00000000;
    w[bpmr_pkg::BPMR_PM_WAKE_EN_BIT] = en;
    w[bpmr_pkg::BPMR_PM_NO_SOFT_RST_BIT] = 1'b1;
    w[1:0] = ps;
    return w;
  endfunction

  // select line for a type 0 target, with masked devices moved to line 31
  function automatic logic [31:0] bpmr_idsel(input logic [4:0] dev, input logic [31:0] msk);
    logic [31:0] line;
    logic [31:0] eff;
    line = 32'h00000000;
    eff = msk & bpmr_pkg::BPMR_DEVMSK_IMPL;
    if (dev < 5'h10)
    begin
      line[5'(dev) + 5'(bpmr_pkg::BPMR_IDSEL_BASE)] = 1'b1;
      if (eff[5'(dev) + 5'(bpmr_pkg::BPMR_IDSEL_BASE)])
        line = 32'h80000000;
    end
    return line;
  endfunction

  // next state: configuration writes, eeprom sequencing, rerouting
  always_comb
  begin
    next_st = st;
    next_st.ee_req.start = 1'b0;
    next_st.rvalid = 1'b0;
    // a cold wake restores the enable captured on D3 entry
    if (cold_wake)
      next_st.wake_event_enable = st.wake_retained;
    // a power word write in the same cycle wins over the cold wake reload
    if (cfg_wr && cfg_addr == bpmr_pkg::BPMR_OFF_PMCS)
    begin
      next_st.wake_event_enable = cfg_wdata[bpmr_pkg::BPMR_PM_WAKE_EN_BIT];
      next_st.power_state_field = bpmr_ps_next(st.power_state_field, cfg_wdata[1:0]);
      if (bpmr_ps_next(st.power_state_field, cfg_wdata[1:0]) == bpmr_pkg::BPMR_PS_D3HOT)
        next_st.wake_retained = cfg_wdata[bpmr_pkg::BPMR_PM_WAKE_EN_BIT];
    end
    // writes during an operation are dropped whole, so a running transfer never sees its fields move
    if (cfg_wr && cfg_addr == bpmr_pkg::BPMR_OFF_EECMD && !st.busy)
    begin
      next_st.ee_cmd = cfg_wdata[bpmr_pkg::BPMR_EE_CMD_LSB +: 2];
      next_st.ee_width = cfg_wdata[bpmr_pkg::BPMR_EE_WIDTH_LSB +: 2];
      next_st.ee_addr = cfg_wdata[bpmr_pkg::BPMR_EE_ADDR_LSB +: 16];
      next_st.ee_data = cfg_wdata[7:0];
      if (cfg_wdata[bpmr_pkg::BPMR_EE_VALID_BIT]
          && cfg_wdata[bpmr_pkg::BPMR_EE_WIDTH_LSB +: 2] != bpmr_pkg::BPMR_EE_NO_DEVICE
          && (cfg_wdata[bpmr_pkg::BPMR_EE_CMD_LSB +: 2] == bpmr_pkg::BPMR_EE_CMD_READ
          || cfg_wdata[bpmr_pkg::BPMR_EE_CMD_LSB +: 2] == bpmr_pkg::BPMR_EE_CMD_WRITE))
      begin
        next_st.busy = 1'b1;
        next_st.ee_state = bpmr_pkg::BPMR_EE_WAIT;
        next_st.ee_req.start = 1'b1;
        next_st.ee_req.cmd = cfg_wdata[bpmr_pkg::BPMR_EE_CMD_LSB +: 2];
        next_st.ee_req.width = cfg_wdata[bpmr_pkg::BPMR_EE_WIDTH_LSB +: 2];
        next_st.ee_req.addr = cfg_wdata[bpmr_pkg::BPMR_EE_ADDR_LSB +: 16];
        next_st.ee_req.data = cfg_wdata[7:0];
      end
    end
    // engine answer closes the operation
    case (st.ee_state)
      bpmr_pkg::BPMR_EE_IDLE:
        next_st.ee_state = next_st.ee_state;
      bpmr_pkg::BPMR_EE_WAIT:
        if (ee_rsp.done)
        begin
          if (st.ee_cmd == bpmr_pkg::BPMR_EE_CMD_READ)
            next_st.ee_data = ee_rsp.data;
          next_st.busy = 1'b0;
          next_st.ee_state = bpmr_pkg::BPMR_EE_IDLE;
        end
      default:
        next_st.ee_state = bpmr_pkg::BPMR_EE_IDLE;
    endcase
    // reserved mask bits are never stored, so they cannot leak into the select decode
    if (cfg_wr && cfg_addr == bpmr_pkg::BPMR_OFF_DEVMSK)
      next_st.secondary_device_select_mask = cfg_wdata & bpmr_pkg::BPMR_DEVMSK_IMPL;
    // read image built from current state; data holds until the next read
    if (cfg_rd)
    begin
      next_st.rvalid = 1'b1;
      case (cfg_addr)
        bpmr_pkg::BPMR_OFF_PMCS:
          next_st.rdata = bpmr_pmcs_image(st.power_state_field, st.wake_event_enable);
        bpmr_pkg::BPMR_OFF_EECMD:
          next_st.rdata = {2'h0, st.ee_cmd, st.ee_width, st.busy, 1'b0, st.ee_addr, st.ee_data};
        bpmr_pkg::BPMR_OFF_DEVMSK:
          next_st.rdata = st.secondary_device_select_mask;
        default:
          next_st.rdata = 32'h00000000;
      endcase
    end
    // select line and wake output are registered, costing one cycle of latency
    next_st.idsel = bpmr_idsel(t0_device, st.secondary_device_select_mask);
    next_st.wake_event = pme_request && st.wake_event_enable;
  end

  // all state registers; eeprom fields have no documented reset, zero is chosen
  always_ff @(posedge clk or negedge rst_sync)
  begin
    // constants only here, so no output pulses before the first clean edge
    if (!rst_sync)
    begin
      st <= '0;
      st.power_state_field <= bpmr_pkg::BPMR_PS_D0;
      st.wake_event_enable <= bpmr_pkg::BPMR_WAKE_EN_RESET;
      st.ee_state <= bpmr_pkg::BPMR_EE_IDLE;
      st.secondary_device_select_mask <= bpmr_pkg::BPMR_DEVMSK_RESET;
    end
    else
      st <= next_st;
  end

  // outputs come straight from the state flops
  assign cfg_rdata = st.rdata;
  assign cfg_rvalid = st.rvalid;
  assign wake_event = st.wake_event;
  assign ee_req = st.ee_req;
  assign t0_idsel = st.idsel;

  // power state, wake enable, eeprom busy/read and device mask rerouting checks
  chk_ps_unsupported: assert property (@(posedge clk) disable iff (!rst_sync)
    cfg_wr && cfg_addr == bpmr_pkg::BPMR_OFF_PMCS && (cfg_wdata[1:0] == 2'h1 || cfg_wdata[1:0] == 2'h2)
    |=> $stable(st.power_state_field)) else $error("unsupported power state taken");
  chk_ps_taken: assert property (@(posedge clk) disable iff (!rst_sync)
    cfg_wr && cfg_addr == bpmr_pkg::BPMR_OFF_PMCS && cfg_wdata[1:0] != 2'h1 && cfg_wdata[1:0] != 2'h2
    |=> st.power_state_field == $past(cfg_wdata[1:0])) else $error("power state not taken");
  chk_pm_readback: assert property (@(posedge clk) disable iff (!rst_sync)
    cfg_rd && cfg_addr == bpmr_pkg::BPMR_OFF_PMCS
    |=> cfg_rvalid && cfg_rdata[7:4] == 4'h0 && !cfg_rdata[2] && cfg_rdata[3]) else $error("pm reserved bits wrong");
  chk_wake_gate: assert property (@(posedge clk) disable iff (!rst_sync)
    wake_event |-> $past(pme_request) && $past(st.wake_event_enable)) else $error("wake event while disabled");
  chk_busy_start: assert property (@(posedge clk) disable iff (!rst_sync)
    $rose(st.busy) |-> $past(cfg_wr) && $past(cfg_wdata[24]) && ee_req.start) else $error("busy without valid command");
  chk_read_done: assert property (@(posedge clk) disable iff (!rst_sync)
    st.busy && ee_rsp.done && st.ee_cmd == bpmr_pkg::BPMR_EE_CMD_READ
    |=> !st.busy && st.ee_data == $past(ee_rsp.data)) else $error("read byte not stored");
  chk_reroute_line: assert property (@(posedge clk) disable iff (!rst_sync)
    t0_device < 5'h10 && st.secondary_device_select_mask[5'(t0_device) + 5'h10]
    ##1 $stable(st.secondary_device_select_mask) |-> t0_idsel == 32'h80000000) else $error("masked device not rerouted");
  chk_mask_clear: assert property (@(posedge clk) disable iff (!rst_sync)
    st.secondary_device_select_mask == 32'h0 && t0_device < 5'h10
    |=> t0_idsel == 32'h1 << ($past(t0_device) + 5'h10)) else $error("unmasked device moved");
  chk_mask_reserved: assert property (@(posedge clk) disable iff (!rst_sync)
    (st.secondary_device_select_mask & ~bpmr_pkg::BPMR_DEVMSK_IMPL) == 32'h0) else $error("reserved mask bit set");

  // wake path, power state and read answer timing invariants
  chk_wake_off: assert property (@(posedge clk) disable iff (!rst_sync)
    !st.wake_event_enable |=> !wake_event) else $error("wake event with enable clear");
  chk_wake_on: assert property (@(posedge clk) disable iff (!rst_sync)
    pme_request && st.wake_event_enable |=> wake_event) else $error("wake event missing");
  chk_cold_restore: assert property (@(posedge clk) disable iff (!rst_sync)
    cold_wake && !(cfg_wr && cfg_addr == bpmr_pkg::BPMR_OFF_PMCS)
    |=> st.wake_event_enable == $past(st.wake_retained)) else $error("cold wake enable not restored");
  chk_retain_capture: assert property (@(posedge clk) disable iff (!rst_sync)
    cfg_wr && cfg_addr == bpmr_pkg::BPMR_OFF_PMCS && cfg_wdata[1:0] == 2'h3
    |=> st.wake_retained == $past(cfg_wdata[8])) else $error("enable not retained on D3 entry");
  chk_pm_high_zero: assert property (@(posedge clk) disable iff (!rst_sync)
    cfg_rd && cfg_addr == bpmr_pkg::BPMR_OFF_PMCS |=> cfg_rdata[31:9] == 23'h0) else $error("pm high bits set");
  chk_ps_legal: assert property (@(posedge clk) disable iff (!rst_sync)
    st.power_state_field != 2'h1 && st.power_state_field != 2'h2) else $error("unsupported power state held");
  chk_rvalid_pulse: assert property (@(posedge clk) disable iff (!rst_sync)
    cfg_rvalid == $past(cfg_rd)) else $error("read answer timing wrong");

  // eeprom command sequencing
  chk_write_lands: assert property (@(posedge clk) disable iff (!rst_sync)
    !st.busy && cfg_wr && cfg_addr == bpmr_pkg::BPMR_OFF_EECMD
    |=> st.ee_cmd == $past(cfg_wdata[29:28])) else $error("command field not stored");
  chk_cmd_decode: assert property (@(posedge clk) disable iff (!rst_sync)
    ee_req.start |-> ee_req.cmd == bpmr_pkg::BPMR_EE_CMD_READ || ee_req.cmd == bpmr_pkg::BPMR_EE_CMD_WRITE)
    else $error("start with undefined command");
  chk_no_device: assert property (@(posedge clk) disable iff (!rst_sync)
    cfg_wr && cfg_addr == bpmr_pkg::BPMR_OFF_EECMD && cfg_wdata[27:26] == 2'h0 |=> !ee_req.start)
    else $error("start without eeprom");
  chk_no_start_invalid: assert property (@(posedge clk) disable iff (!rst_sync)
    cfg_wr && cfg_addr == bpmr_pkg::BPMR_OFF_EECMD && !cfg_wdata[24] |=> !ee_req.start)
    else $error("start without valid bit");
  chk_valid_reads_zero: assert property (@(posedge clk) disable iff (!rst_sync)
    cfg_rd && cfg_addr == bpmr_pkg::BPMR_OFF_EECMD |=> !cfg_rdata[24] && cfg_rdata[31:30] == 2'h0)
    else $error("eeprom reserved or valid bit reads one");
  chk_busy_read: assert property (@(posedge clk) disable iff (!rst_sync)
    cfg_rd && cfg_addr == bpmr_pkg::BPMR_OFF_EECMD |=> cfg_rdata[25] == $past(st.busy)) else $error("busy misreported");
  chk_busy_hold: assert property (@(posedge clk) disable iff (!rst_sync)
    st.busy && !ee_rsp.done |=> st.busy) else $error("busy dropped early");
  chk_start_busy: assert property (@(posedge clk) disable iff (!rst_sync)
    ee_req.start |-> st.busy && st.ee_state == bpmr_pkg::BPMR_EE_WAIT) else $error("start while not busy");
  chk_start_pulse: assert property (@(posedge clk) disable iff (!rst_sync)
    ee_req.start |=> !ee_req.start) else $error("start longer than one cycle");
  chk_ee_refused: assert property (@(posedge clk) disable iff (!rst_sync)
    st.busy && cfg_wr && cfg_addr == bpmr_pkg::BPMR_OFF_EECMD
    |=> $stable(st.ee_addr) && $stable(st.ee_cmd) && $stable(st.ee_width)) else $error("write taken while busy");
  chk_req_fields: assert property (@(posedge clk) disable iff (!rst_sync)
    ee_req.start |-> ee_req.addr == st.ee_addr && ee_req.data == st.ee_data && ee_req.width == st.ee_width)
    else $error("request fields differ from register");

  // device mask and select lines
  chk_mask_write: assert property (@(posedge clk) disable iff (!rst_sync)
    cfg_wr && cfg_addr == bpmr_pkg::BPMR_OFF_DEVMSK
    |=> st.secondary_device_select_mask == ($past(cfg_wdata) & bpmr_pkg::BPMR_DEVMSK_IMPL)) else $error("mask not stored");
  chk_mask_read: assert property (@(posedge clk) disable iff (!rst_sync)
    cfg_rd && cfg_addr == bpmr_pkg::BPMR_OFF_DEVMSK
    |=> (cfg_rdata & ~bpmr_pkg::BPMR_DEVMSK_IMPL) == 32'h0) else $error("reserved mask bit reads one");
  chk_high_device: assert property (@(posedge clk) disable iff (!rst_sync)
    t0_device >= 5'h10 |=> t0_idsel == 32'h0) else $error("select line for absent device");
  chk_idsel_onehot: assert property (@(posedge clk) disable iff (!rst_sync)
    $onehot0(t0_idsel)) else $error("more than one select line");
endmodule // bpmr_regs
`default_nettype wire

// ---- bench/bpmr_ee_model.sv ----
// bpmr_ee_model: serial eeprom engine on the far side of the request port.
// assumes request fields stand from start until the done pulse.
`default_nettype none
module bpmr_ee_model (
  input wire logic clk,
  input wire bpmr_pkg::bpmr_ee_req_t ee_req,
  output var bpmr_pkg::bpmr_ee_rsp_t ee_rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  initial ee_rsp = '0;
  // slow answer of 6..11 cycles; data toggles outside done so stale bytes never pass
  always @(posedge clk)
  begin
    if (ee_req.start)
      cnt <= 6 + $urandom % 6;
    else if (cnt != 0)
      cnt <= cnt - 1;
    ee_rsp.done <= (cnt == 1) && !ee_req.start;
    if (cnt == 1 && ee_req.cmd == bpmr_pkg::BPMR_EE_CMD_READ)
      ee_rsp.data <= ee_req.addr[7:0] ^ 8'hA5;
    else if (cnt == 1)
      ee_rsp.data <= ee_req.data;
    else
      ee_rsp.data <= ~ee_rsp.data;
  end
endmodule // bpmr_ee_model
`default_nettype wire

// ---- bench/tb_bridge_pm_eeprom_idsel_regs.sv ----
// tb_bridge_pm_eeprom_idsel_regs: self-checking bench for the bpmr register block.
// assumes one 100 MHz clock and the eeprom model on the request port.
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_bridge_pm_eeprom_idsel_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, resetn = 0, cold_wake = 0, cfg_wr = 0, cfg_rd = 0, pme_request = 0;
  logic cfg_rvalid, wake_event;
  logic [11:0] cfg_addr = '0;
  logic [31:0] cfg_wdata = '0, cfg_rdata, t0_idsel, m, q, expq[$];
  logic [4:0] t0_device = '0;
  logic [15:0] a;
  logic [7:0] d;
  logic [1:0] c, w;
  bpmr_pkg::bpmr_ee_req_t ee_req;
  bpmr_pkg::bpmr_ee_rsp_t ee_rsp;
  int fail_count = 0, samples_checked = 0, cycles = 0;
  always #5 clk = ~clk;
  bpmr_regs bpmr_regs_i (.clk(clk), .resetn(resetn), .cold_wake(cold_wake), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .pme_request(pme_request), .wake_event(wake_event),
    .ee_req(ee_req), .ee_rsp(ee_rsp), .t0_device(t0_device), .t0_idsel(t0_idsel));
  bpmr_ee_model bpmr_ee_model_i (.clk(clk), .ee_req(ee_req), .ee_rsp(ee_rsp));
  task automatic test_done();
    $display("compared %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [11:0] ad, input logic [31:0] v);
    @(posedge clk);
    cfg_wr <= 1'b1;
    cfg_addr <= ad;
    cfg_wdata <= v;
    @(posedge clk);
    cfg_wr <= 1'b0;
  endtask
  // the expected answer is noted before the strobe goes out
  task automatic rd(input logic [11:0] ad, input logic [31:0] e);
    expq.push_back(e);
    @(posedge clk);
    cfg_rd <= 1'b1;
    cfg_addr <= ad;
    @(posedge clk);
    cfg_rd <= 1'b0;
  endtask
  // power word write, read back, then wake output follows the enable with pme held high
  task automatic pm(input logic [31:0] v, input logic [31:0] e);
    wr(12'h0A4, v);
    rd(12'h0A4, e);
    @(negedge clk);
    `CHK("wake_event", e[8], wake_event)
  endtask
  task automatic sel(input logic [4:0] dv, input logic [31:0] mk);
    @(posedge clk);
    t0_device <= dv;
    @(posedge clk);
    @(negedge clk);
    q = dv[4] ? 32'h0 : (mk & 32'h22F20000) >> (16 + dv) & 1 ? 32'h80000000 : 32'h1 << (16 + dv);
    `CHK("t0_idsel", q, t0_idsel)
  endtask
  // read answers are matched against the oldest note
  always @(posedge clk)
    if (cfg_rvalid === 1'b1)
    begin
      q = expq.pop_front();
      `CHK("cfg_rdata", q, cfg_rdata)
    end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      test_done();
    end
  end
  initial
  begin
    void'($urandom(32'h0593));
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    pme_request <= 1'b1;
    rd(12'h0A4, 32'h8);
    rd(12'h0B0, 32'h0);
    pm(32'hFFFFFFFF, 32'h10B);
    pm(32'h101, 32'h10B);
    pm(32'h002, 32'h00B);
    pm(32'h100, 32'h108);
    pm(32'h103, 32'h10B);
    pm(32'h000, 32'h008);
    @(posedge clk);
    cold_wake <= 1'b1;
    @(posedge clk);
    cold_wake <= 1'b0;
    rd(12'h0A4, 32'h108);
    for (int i = 0; i < 4; i++)
    begin
      a = 16'($urandom);
      d = 8'($urandom);
      c = 2'(1 + i % 2);
      w = 2'(1 + $urandom % 2);
      wr(12'h0AC, {2'b00, c, w, 2'b01, a, d});
      wr(12'h0AC, {2'b00, 2'b10, 2'b10, 2'b01, 24'h0});
      rd(12'h0AC, {2'b00, c, w, 2'b10, a, d});
      `CHK("ee_req.addr", a, ee_req.addr)
      `CHK("ee_req.data", d, ee_req.data)
      `CHK("ee_req.cmd", c, ee_req.cmd)
      `CHK("ee_req.width", w, ee_req.width)
      for (int k = 0; k < 40 && ee_rsp.done !== 1'b1; k++)
        @(posedge clk);
      rd(12'h0AC, {2'b00, c, w, 2'b00, a, c == 2'b01 ? a[7:0] ^ 8'hA5 : d});
    end
    wr(12'h0AC, {8'h11, a, d});
    rd(12'h0AC, {8'h10, a, d});
    for (int i = 0; i < 3; i++)
    begin
      m = i == 0 ? 32'hFFFFFFFF : i == 1 ? 32'h0 : $urandom;
      wr(12'h0B0, m);
      rd(12'h0B0, m & 32'h22F20000);
      for (int dv = 0; dv < 32; dv++)
        sel(5'(dv), m);
    end
    repeat (3) @(posedge clk);
    `CHK("pending reads", 0, expq.size())
    test_done();
  end
endmodule // tb_bridge_pm_eeprom_idsel_regs
`undef CHK
`default_nettype wire
